// ### rtl/rsc_pkg.sv
// shared constants and types for the remote status and self-test command block
package rsc_pkg;
   // command codes presented on the decoded command port
   typedef enum logic [3:0] {
      RSC_CMD_NOP = 4'h0,
      RSC_CMD_SAV = 4'h1,
      RSC_CMD_RCL = 4'h2,
      RSC_CMD_RST = 4'h3,
      RSC_CMD_CLS = 4'h4,
      RSC_CMD_MASK_WR = 4'h5,
      RSC_CMD_MASK_RD = 4'h6,
      RSC_CMD_SBYTE_RD = 4'h7,
      RSC_CMD_TST = 4'h8,
      RSC_CMD_WAI = 4'h9,
      RSC_CMD_DISP = 4'hA,
      RSC_CMD_LOCK = 4'hB,
      RSC_CMD_LOCK_RD = 4'hC,
      RSC_CMD_DISP_RD = 4'hD
   } rsc_cmd_t;
   // main sequencer states
   typedef enum logic [2:0] {
      RSC_ST_IDLE = 3'b000,
      RSC_ST_TEST = 3'b001,
      RSC_ST_RESTORE = 3'b010,
      RSC_ST_DRAIN = 3'b011,
      RSC_ST_SETTLE = 3'b100
   } rsc_state_t;
   // decoded command with its argument
   typedef struct packed {
      rsc_cmd_t op;
      logic [15:0] arg;
   } rsc_req_t;
   // status byte inputs from the rest of the instrument
   typedef struct packed {
      logic oper_sum;
      logic event_sum;
      logic msg_avail;
      logic ques_sum;
   } rsc_status_t;
   // widths and layout
   localparam int RSC_SET_W = 32;
   localparam int RSC_SLOTS = 6;
   localparam logic [2:0] RSC_SLOT_MIN = 3'h1;
   localparam logic [2:0] RSC_SLOT_MAX = 3'h5;
   localparam logic [2:0] RSC_SLOT_DEF = 3'h0;
   localparam int RSC_SB_OPER = 7;
   localparam int RSC_SB_RQS = 6;
   localparam int RSC_SB_ESB = 5;
   localparam int RSC_SB_MAV = 4;
   localparam int RSC_SB_QUES = 3;
   // self-test result bits that carry a failure weight
   localparam logic [15:0] RSC_TST_MASK = 16'hE07F;
   // reset values
   localparam logic [7:0] RSC_MASK_RST = 8'h00;
   localparam logic RSC_DISP_RST = 1'b1;
   localparam logic RSC_LOCK_RST = 1'b0;
   localparam logic [RSC_SET_W-1:0] RSC_DEFAULT_SET = 32'h0000_0000;
   // settle delay after wait-to-continue
   localparam int RSC_CLK_MHZ = 200;
   localparam int RSC_SETTLE_MS = 100;
   localparam int RSC_SETTLE_CYC = RSC_SETTLE_MS * 1000 * RSC_CLK_MHZ;
   // self-test run time in cycles before the failures are sampled
   localparam int RSC_TEST_CYC = 16;
endpackage : rsc_pkg

// ### rtl/rsc_setmem.sv
// small setting store: slot 0 holds defaults, slots 1-5 user settings
`timescale 1ns/1ps
`default_nettype none
module rsc_setmem #(
   parameter int W = 32,
   parameter int DEPTH = 6
) (
   // clock
   input wire logic sys_clk,
   // write port
   input wire logic wr_en,
   input wire logic [2:0] wr_addr,
   input wire logic [W-1:0] wr_data,
   // read port, data registered
   input wire logic [2:0] rd_addr,
   output logic [W-1:0] rd_data
);
   logic [W-1:0] mem [DEPTH];
   // storage holds no reset; slot 0 is never written and reads of it return RSC_DEFAULT_SET
   always_ff @(posedge sys_clk) begin
      if (wr_en && wr_addr != 3'h0 && int'(wr_addr) < DEPTH) begin
         mem[wr_addr] <= wr_data;
      end
      if (rd_addr == 3'h0 || int'(rd_addr) >= DEPTH) begin
         rd_data <= W'(rsc_pkg::RSC_DEFAULT_SET);
      end else begin
         rd_data <= mem[rd_addr];
      end
   end
endmodule // rsc_setmem
`default_nettype wire

// ### rtl/rsc_weigher.sv
// folds per-check failures into the weighted self-test result word
`timescale 1ns/1ps
`default_nettype none
module rsc_weigher (
   // clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // capture strobe and raw failures, bit n weighs 2**n
   input wire logic capture,
   input wire logic [15:0] fails,
   // registered result
   output logic [15:0] result
);
   logic [15:0] result_next;
   // unused positions never contribute, so the sum is the masked word
   always_comb begin
      result_next = result;
      if (capture) begin
         result_next = fails & rsc_pkg::RSC_TST_MASK;
      end
   end
   // result register
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         result <= 16'h0000;
      end else begin
         result <= result_next;
      end
   end
endmodule // rsc_weigher
`default_nettype wire

// ### rtl/rsc_top.sv
// command interpreter for save/recall, status byte, self-test, wait, display and lock
// How it works
// - save copies live setting to slots 1-5
// - saved scope equals reset scope
// - host writes 0-255 enabling status bits
// - enable mask clears at reset, zero write
// - reset and clear-status keep enable mask
// - mask query returns mask contents
// - bit 6 never masked
// - status byte layout, bits 2-0 zero
// - self-test query returns result word
// - result is sum of failure weights
// - zero result means all passed
// - failures also pushed to error queue
// - commands refused while self-test runs
// - setting restored after self-test
// - wait drains then settles 0.1 s
// - display enable, on by default
// - lock command sets or clears lock
// - lock forces laser off next cycle
// - recall slots 1-5, slot 0 defaults
`timescale 1ns/1ps
`default_nettype none
module rsc_top #(
   parameter int SET_W = rsc_pkg::RSC_SET_W,
   parameter int SETTLE_CYC = rsc_pkg::RSC_SETTLE_CYC,
   parameter int TEST_CYC = rsc_pkg::RSC_TEST_CYC
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // decoded command port
   input wire logic cmd_valid,
   input wire rsc_pkg::rsc_req_t cmd,
   output logic cmd_ready,
   // query answers
   output logic resp_valid,
   output logic [15:0] resp_data,
   // error queue push
   output logic err_push,
   output logic [15:0] err_data,
   // instrument setting and its loading
   input wire logic [SET_W-1:0] live_set,
   output logic set_load,
   output logic [SET_W-1:0] set_value,
   // status sources and pending operations
   input wire rsc_pkg::rsc_status_t status,
   input wire logic ops_pending,
   // self-test hooks
   output logic test_run,
   input wire logic [15:0] test_fails,
   // front panel and laser
   output logic disp_on,
   output logic lock_on,
   output logic laser_kill,
   // status byte as a level
   output logic [7:0] sbyte
);
   // timer must hold the longer of the two loads
   localparam int CW = $clog2(((SETTLE_CYC > TEST_CYC) ? SETTLE_CYC : TEST_CYC) + 1) + 1;

   rsc_pkg::rsc_state_t st_reg, st_next;
   logic [CW-1:0] cnt_reg, cnt_next; // test and settle timer
   logic [7:0] mask_reg, mask_next; // service request mask
   logic disp_reg, disp_next;
   logic lock_reg, lock_next;
   logic kill_reg, kill_next;
   logic [SET_W-1:0] held_reg, held_next; // setting held across self-test
   logic rdy_reg, rdy_next;
   logic rv_reg, rv_next;
   logic [15:0] rd_reg, rd_next;
   logic ep_reg, ep_next;
   logic [15:0] ed_reg, ed_next;
   logic ld_reg, ld_next;
   logic [SET_W-1:0] sv_reg, sv_next;
   logic tr_reg, tr_next;
   logic [7:0] sb_reg, sb_next;
   logic rcl_pend_reg, rcl_pend_next; // memory read lags one cycle
   logic mem_wr, cap;
   logic [2:0] mem_ra;
   logic [SET_W-1:0] mem_rd;
   logic [15:0] tst_result;
   logic take;
   logic [7:0] sb_raw;

   // setting slots; the saved word is the full live setting, the same
   // field set that defaults restore
   rsc_setmem #(.W(SET_W), .DEPTH(rsc_pkg::RSC_SLOTS)) u_mem (
      .sys_clk(sys_clk),
      .wr_en(mem_wr),
      .wr_addr(cmd.arg[2:0]),
      .wr_data(live_set),
      .rd_addr(mem_ra),
      .rd_data(mem_rd)
   );

   // weighted self-test result
   rsc_weigher u_wgt (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .capture(cap),
      .fails(test_fails),
      .result(tst_result)
   );

   // a command is taken only when idle and ready
   assign take = cmd_valid && rdy_reg;
   // only in-range slots are written
   assign mem_wr = take && cmd.op == rsc_pkg::RSC_CMD_SAV && cmd.arg[15:3] == 13'h0
      && cmd.arg[2:0] >= rsc_pkg::RSC_SLOT_MIN && cmd.arg[2:0] <= rsc_pkg::RSC_SLOT_MAX;
   // defaults come from slot 0 on reset command
   assign mem_ra = (cmd.op == rsc_pkg::RSC_CMD_RST) ? rsc_pkg::RSC_SLOT_DEF : cmd.arg[2:0];
   assign cap = (st_reg == rsc_pkg::RSC_ST_TEST) && cnt_reg == '0;

   // live status byte; request bit derived, never masked itself
   always_comb begin
      sb_raw = 8'h00; // bits 2-0 stay zero
      sb_raw[rsc_pkg::RSC_SB_OPER] = status.oper_sum;
      sb_raw[rsc_pkg::RSC_SB_ESB] = status.event_sum;
      sb_raw[rsc_pkg::RSC_SB_MAV] = status.msg_avail;
      sb_raw[rsc_pkg::RSC_SB_QUES] = status.ques_sum;
      sb_raw[rsc_pkg::RSC_SB_RQS] = |(sb_raw & mask_reg & 8'hBF);
   end

   // next-state logic for the whole sequencer
   always_comb begin
      st_next = st_reg;
      cnt_next = cnt_reg;
      mask_next = mask_reg;
      disp_next = disp_reg;
      lock_next = lock_reg;
      kill_next = 1'b0;
      held_next = held_reg;
      rdy_next = rdy_reg;
      rv_next = 1'b0;
      rd_next = rd_reg;
      ep_next = 1'b0;
      ed_next = ed_reg;
      ld_next = 1'b0;
      sv_next = sv_reg;
      tr_next = tr_reg;
      rcl_pend_next = 1'b0;
      sb_next = sb_raw;
      // recall data arrives one cycle after the request
      if (rcl_pend_reg) begin
         ld_next = 1'b1;
         sv_next = mem_rd;
      end
      case (st_reg)
         rsc_pkg::RSC_ST_IDLE: begin
            if (take) begin
               case (cmd.op)
                  rsc_pkg::RSC_CMD_MASK_WR: mask_next = cmd.arg[7:0];
                  rsc_pkg::RSC_CMD_MASK_RD: begin
                     rv_next = 1'b1;
                     rd_next = {8'h00, mask_reg};
                  end
                  rsc_pkg::RSC_CMD_SBYTE_RD: begin
                     rv_next = 1'b1;
                     rd_next = {8'h00, sb_raw};
                  end
                  // reset and clear-status leave the mask alone
                  rsc_pkg::RSC_CMD_RST: rcl_pend_next = 1'b1;
                  rsc_pkg::RSC_CMD_CLS: rcl_pend_next = 1'b0;
                  rsc_pkg::RSC_CMD_RCL: begin
                     // out-of-range slots are ignored
                     rcl_pend_next = cmd.arg <= 16'h0005;
                  end
                  rsc_pkg::RSC_CMD_TST: begin
                     held_next = live_set;
                     tr_next = 1'b1;
                     rdy_next = 1'b0;
                     cnt_next = CW'(TEST_CYC);
                     st_next = rsc_pkg::RSC_ST_TEST;
                  end
                  rsc_pkg::RSC_CMD_WAI: begin
                     rdy_next = 1'b0;
                     st_next = rsc_pkg::RSC_ST_DRAIN;
                  end
                  rsc_pkg::RSC_CMD_DISP: disp_next = cmd.arg[0];
                  rsc_pkg::RSC_CMD_DISP_RD: begin
                     rv_next = 1'b1;
                     rd_next = {15'h0000, disp_reg};
                  end
                  rsc_pkg::RSC_CMD_LOCK: begin
                     // password digits ride in arg[15:1] and are not checked here
                     lock_next = cmd.arg[0];
                     kill_next = cmd.arg[0];
                  end
                  rsc_pkg::RSC_CMD_LOCK_RD: begin
                     rv_next = 1'b1;
                     rd_next = {15'h0000, lock_reg};
                  end
                  default: ;
               endcase
            end
         end
         rsc_pkg::RSC_ST_TEST: begin
            // run the test for a fixed time, weigher captures at zero
            if (cnt_reg == '0) begin
               tr_next = 1'b0;
               st_next = rsc_pkg::RSC_ST_RESTORE;
            end else begin
               cnt_next = cnt_reg - CW'(1);
            end
         end
         rsc_pkg::RSC_ST_RESTORE: begin
            rv_next = 1'b1;
            rd_next = tst_result;
            ep_next = tst_result != 16'h0000;
            ed_next = tst_result;
            ld_next = 1'b1;
            sv_next = held_reg;
            rdy_next = 1'b1;
            st_next = rsc_pkg::RSC_ST_IDLE;
         end
         rsc_pkg::RSC_ST_DRAIN: begin
            if (!ops_pending) begin
               cnt_next = CW'(SETTLE_CYC);
               st_next = rsc_pkg::RSC_ST_SETTLE;
            end
         end
         rsc_pkg::RSC_ST_SETTLE: begin
            if (cnt_reg <= CW'(1)) begin
               rdy_next = 1'b1;
               st_next = rsc_pkg::RSC_ST_IDLE;
            end else begin
               cnt_next = cnt_reg - CW'(1);
            end
         end
         default: st_next = rsc_pkg::RSC_ST_IDLE;
      endcase
   end

   // register stage
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         st_reg <= rsc_pkg::RSC_ST_IDLE;
         cnt_reg <= '0;
         mask_reg <= rsc_pkg::RSC_MASK_RST;
         disp_reg <= rsc_pkg::RSC_DISP_RST;
         lock_reg <= rsc_pkg::RSC_LOCK_RST;
         kill_reg <= 1'b0;
         held_reg <= '0;
         rdy_reg <= 1'b1;
         rv_reg <= 1'b0;
         rd_reg <= 16'h0000;
         ep_reg <= 1'b0;
         ed_reg <= 16'h0000;
         ld_reg <= 1'b0;
         sv_reg <= '0;
         tr_reg <= 1'b0;
         sb_reg <= 8'h00;
         rcl_pend_reg <= 1'b0;
      end else begin
         st_reg <= st_next;
         cnt_reg <= cnt_next;
         mask_reg <= mask_next;
         disp_reg <= disp_next;
         lock_reg <= lock_next;
         kill_reg <= kill_next;
         held_reg <= held_next;
         rdy_reg <= rdy_next;
         rv_reg <= rv_next;
         rd_reg <= rd_next;
         ep_reg <= ep_next;
         ed_reg <= ed_next;
         ld_reg <= ld_next;
         sv_reg <= sv_next;
         tr_reg <= tr_next;
         sb_reg <= sb_next;
         rcl_pend_reg <= rcl_pend_next;
      end
   end

   assign cmd_ready = rdy_reg;
   assign resp_valid = rv_reg;
   assign resp_data = rd_reg;
   assign err_push = ep_reg;
   assign err_data = ed_reg;
   assign set_load = ld_reg;
   assign set_value = sv_reg;
   assign test_run = tr_reg;
   assign disp_on = disp_reg;
   assign lock_on = lock_reg;
   assign laser_kill = kill_reg;
   assign sbyte = sb_reg;

   // mask write lands next cycle
   chk_mask_write: assert property (@(posedge sys_clk) disable iff (!nrst)
      take && cmd.op == rsc_pkg::RSC_CMD_MASK_WR |=> mask_reg == $past(cmd.arg[7:0]))
      else $error("mask write lost");
   // reset and clear keep mask
   chk_mask_keep: assert property (@(posedge sys_clk) disable iff (!nrst)
      take && (cmd.op == rsc_pkg::RSC_CMD_RST || cmd.op == rsc_pkg::RSC_CMD_CLS)
      |=> $stable(mask_reg))
      else $error("mask changed by reset or clear");
   // low bits of status byte are zero
   chk_sbyte_low: assert property (@(posedge sys_clk) disable iff (!nrst)
      sbyte[2:0] == 3'h0)
      else $error("status low bits set");
   // request bit follows enabled bits
   chk_rqs_calc: assert property (@(posedge sys_clk) disable iff (!nrst)
      ##1 sbyte[6] == |($past(sb_raw) & $past(mask_reg) & 8'hBF))
      else $error("request bit wrong");
   // no commands taken during test
   chk_tst_busy: assert property (@(posedge sys_clk) disable iff (!nrst)
      test_run |-> !cmd_ready)
      else $error("ready during self-test");
   // failing result goes to the error queue
   chk_err_push: assert property (@(posedge sys_clk) disable iff (!nrst)
      resp_valid && st_reg == rsc_pkg::RSC_ST_IDLE && $past(st_reg) == rsc_pkg::RSC_ST_RESTORE
      |-> err_push == (resp_data != 16'h0000))
      else $error("error push mismatch");
   // lock kills the laser next cycle
   chk_lock_kill: assert property (@(posedge sys_clk) disable iff (!nrst)
      take && cmd.op == rsc_pkg::RSC_CMD_LOCK && cmd.arg[0] |=> laser_kill && lock_on)
      else $error("laser not killed on lock");
   // wait keeps the port not ready for the two cycles after it is taken
   chk_wai_hold: assert property (@(posedge sys_clk) disable iff (!nrst)
      take && cmd.op == rsc_pkg::RSC_CMD_WAI |=> !cmd_ready [*2])
      else $error("wait released early");
endmodule // rsc_top
`default_nettype wire

// ### dv/rsc_host_model.sv
// host controller model that issues decoded commands to the block
`timescale 1ns/1ps
`default_nettype none
module rsc_host_model (
   // clock
   input wire logic sys_clk,
   // command port toward the block
   output logic cmd_valid,
   output rsc_pkg::rsc_req_t cmd,
   input wire logic cmd_ready
);
   // nothing presented from time zero
   initial begin
      cmd_valid = 1'b0;
      cmd = '0;
   end
   // present one command and hold it until the edge that takes it
   task automatic send(input rsc_pkg::rsc_cmd_t op, input logic [15:0] arg);
      cmd_valid <= 1'b1;
      // mask writes only ever carry 0-255
      cmd <= '{op: op, arg: (op == rsc_pkg::RSC_CMD_MASK_WR) ? {8'h00, arg[7:0]} : arg};
      @(posedge sys_clk);
      // no new command while the block is busy; a hang hits the bench ceiling
      while (cmd_ready !== 1'b1) begin
         @(posedge sys_clk);
      end
   endtask
   // release the port; lines flip so a stale command never looks valid
   task automatic idle();
      cmd_valid <= 1'b0;
      cmd <= rsc_pkg::rsc_req_t'(~cmd);
      @(posedge sys_clk);
   endtask
endmodule // rsc_host_model
`default_nettype wire

// ### dv/remote_status_selftest_cmds_bench.sv
// self-checking bench for the remote status and self-test command block
`timescale 1ns/1ps
`default_nettype none
module remote_status_selftest_cmds_bench;
   // design hookup
   logic sys_clk = 1'b0;
   logic nrst, cmd_valid, cmd_ready, resp_valid, err_push, set_load, ops_pending;
   logic test_run, disp_on, lock_on, laser_kill;
   rsc_pkg::rsc_req_t cmd;
   rsc_pkg::rsc_status_t status;
   logic [15:0] resp_data, err_data, test_fails, f;
   logic [31:0] live_set, set_value, v;
   logic [7:0] sbyte, mask, exp_sbyte;
   // expected results, oldest first
   logic [15:0] exp_resp[$], exp_err[$];
   logic [31:0] exp_set[$], slot_val[6];
   int miscompares, num_checks, cycles, kills, seed, n, i;

   // 200 MHz clock
   always #2.5 sys_clk = ~sys_clk;

   rsc_top #(.SETTLE_CYC(8), .TEST_CYC(16)) rsc_top_i (
      .sys_clk(sys_clk), .nrst(nrst), .cmd_valid(cmd_valid), .cmd(cmd),
      .cmd_ready(cmd_ready), .resp_valid(resp_valid), .resp_data(resp_data),
      .err_push(err_push), .err_data(err_data), .live_set(live_set),
      .set_load(set_load), .set_value(set_value), .status(status),
      .ops_pending(ops_pending), .test_run(test_run), .test_fails(test_fails),
      .disp_on(disp_on), .lock_on(lock_on), .laser_kill(laser_kill), .sbyte(sbyte)
   );
   rsc_host_model host_i (
      .sys_clk(sys_clk), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready)
   );

   // one comparison, counted
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic ticks(input int k);
      repeat (k) @(posedge sys_clk);
   endtask
   // query with its answer noted first
   task automatic query(input rsc_pkg::rsc_cmd_t op, input logic [15:0] exp);
      exp_resp.push_back(exp);
      host_i.send(op, 16'h0000);
      host_i.idle();
   endtask
   // bounded wait for the port to come back
   task automatic wait_ready();
      n = 0;
      while (cmd_ready !== 1'b1 && n < 200) begin
         @(posedge sys_clk);
         n++;
      end
      // a port that never returns is a failure in its own right
      if (cmd_ready !== 1'b1) begin
         miscompares++;
         $display("[FAIL] %0t command port never came back", $time);
      end
   endtask
   // single exit point of the run
   task automatic give_verdict();
      if (exp_resp.size() + exp_err.size() + exp_set.size() != 0) begin
         miscompares++;
         $display("[FAIL] %0t results still outstanding", $time);
      end
      if (miscompares == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // output watcher: each pulse takes the oldest note
   always @(posedge sys_clk) begin
      if (nrst === 1'b1) begin
         if (laser_kill === 1'b1)
            kills++;
         if (resp_valid === 1'b1) begin
            if (exp_resp.size() == 0) chk(1'b1, 1'b0, "stray answer");
            else chk(resp_data, exp_resp.pop_front(), "answer");
         end
         if (err_push === 1'b1) begin
            if (exp_err.size() == 0) chk(1'b1, 1'b0, "stray error push");
            else chk(err_data, exp_err.pop_front(), "error push");
         end
         if (set_load === 1'b1) begin
            if (exp_set.size() == 0) chk(1'b1, 1'b0, "stray load");
            else chk(set_value, exp_set.pop_front(), "setting load");
         end
      end
   end

   // hang guard, well above the expected run length
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 6000) begin
         miscompares++;
         $display("[FAIL] %0t timeout", $time);
         give_verdict();
      end
   end

   // main sequence
   initial begin
      seed = 36;
      {miscompares, num_checks, cycles, kills} = '0;
      nrst = 1'b0;
      ops_pending = 1'b0;
      status = '0;
      test_fails = 16'h0000;
      live_set = 32'h0000_0000;
      ticks(5);
      nrst <= 1'b1;
      ticks(1);
      chk({disp_on, lock_on, cmd_ready}, 3'h5, "reset outputs");
      query(rsc_pkg::RSC_CMD_MASK_RD, 16'h0000);
      // mask survives reset and clear-status
      mask = 8'($random(seed));
      exp_set.push_back(rsc_pkg::RSC_DEFAULT_SET);
      host_i.send(rsc_pkg::RSC_CMD_MASK_WR, {8'h00, mask});
      host_i.send(rsc_pkg::RSC_CMD_RST, 16'h0000);
      host_i.send(rsc_pkg::RSC_CMD_CLS, 16'h0000);
      host_i.idle();
      query(rsc_pkg::RSC_CMD_MASK_RD, {8'h00, mask});
      // status byte layout and request summary, first mask only bit 6
      for (i = 0; i < 8; i++) begin
         mask = (i == 0) ? 8'h40 : 8'($random(seed));
         status <= rsc_pkg::rsc_status_t'(4'($random(seed)));
         host_i.send(rsc_pkg::RSC_CMD_MASK_WR, {8'h00, mask});
         host_i.idle();
         ticks(3);
         exp_sbyte = {status.oper_sum, 1'b0, status.event_sum, status.msg_avail,
                      status.ques_sum, 3'b000};
         exp_sbyte[6] = |(exp_sbyte & mask & 8'hBF);
         chk(sbyte, exp_sbyte, "status byte level");
         query(rsc_pkg::RSC_CMD_SBYTE_RD, {8'h00, exp_sbyte});
      end
      // save into slots 1-5, out-of-range saves to slots 0 and 6 ignored
      slot_val[0] = rsc_pkg::RSC_DEFAULT_SET;
      for (i = 1; i < 8; i++) begin
         v = $random(seed);
         if (i < 6) slot_val[i] = v;
         live_set <= v;
         host_i.send(rsc_pkg::RSC_CMD_SAV, (i < 6) ? 16'(i) : 16'(i % 6 * 6));
      end
      for (i = 5; i >= 0; i--) begin
         exp_set.push_back(slot_val[i]);
         host_i.send(rsc_pkg::RSC_CMD_RCL, 16'(i));
      end
      host_i.send(rsc_pkg::RSC_CMD_RCL, 16'h0007);
      host_i.idle();
      ticks(4);
      // self-test with failures, then a clean pass
      for (i = 0; i < 2; i++) begin
         v = $random(seed);
         f = (i == 0) ? 16'($random(seed)) | 16'h0010 : 16'h0000;
         live_set <= v;
         exp_resp.push_back(f & rsc_pkg::RSC_TST_MASK);
         if ((f & rsc_pkg::RSC_TST_MASK) != 16'h0000)
            exp_err.push_back(f & rsc_pkg::RSC_TST_MASK);
         exp_set.push_back(v);
         host_i.send(rsc_pkg::RSC_CMD_TST, 16'h0000);
         host_i.idle();
         test_fails <= f;
         live_set <= ~v;
         ticks(3);
         chk({cmd_ready, test_run}, 2'b01, "busy in self-test");
         wait_ready();
         ticks(2);
      end
      // wait-to-continue drains then settles
      ops_pending <= 1'b1;
      host_i.send(rsc_pkg::RSC_CMD_WAI, 16'h0000);
      host_i.idle();
      ticks(10);
      chk(cmd_ready, 1'b0, "held while pending");
      ops_pending <= 1'b0;
      wait_ready();
      chk(n >= 8 && n <= 14, 1'b1, "settle delay");
      // display off then on
      for (i = 0; i < 2; i++) begin
         host_i.send(rsc_pkg::RSC_CMD_DISP, 16'(i));
         host_i.idle();
         query(rsc_pkg::RSC_CMD_DISP_RD, 16'(i));
      end
      // lock on then off, password digits 4321 beside the state
      host_i.send(rsc_pkg::RSC_CMD_LOCK, 16'h4321);
      host_i.idle();
      chk(lock_on, 1'b1, "lock set");
      query(rsc_pkg::RSC_CMD_LOCK_RD, 16'h0001);
      host_i.send(rsc_pkg::RSC_CMD_LOCK, 16'h4320);
      host_i.idle();
      query(rsc_pkg::RSC_CMD_LOCK_RD, 16'h0000);
      chk(32'(kills), 32'h1, "laser kill pulses");
      // zero write clears the mask
      host_i.send(rsc_pkg::RSC_CMD_MASK_WR, 16'h0000);
      host_i.idle();
      query(rsc_pkg::RSC_CMD_MASK_RD, 16'h0000);
      ticks(4);
      give_verdict();
   end
endmodule // remote_status_selftest_cmds_bench
`default_nettype wire
